/* File: ebutp_pkg.sv */
/*
 * Shared constants of the eight-bit up-counting timer with prescaler:
 * register addresses, field positions, reset values and widths.
 * Assumes the single-clock register port of the timer top module.
 */
package ebutp_pkg;

	// Data and address widths of the register port
	localparam int unsigned EBUTP_DATA_W      = 8;
	localparam int unsigned EBUTP_ADDR_W      = 3;
	localparam int unsigned EBUTP_RATIO_W     = 3;

	// Register addresses
	localparam logic [2:0]  EBUTP_ADDR_COUNT  = 3'h0;  // Live count, load on write
	localparam logic [2:0]  EBUTP_ADDR_MODE   = 3'h1;  // Timer mode register
	localparam logic [2:0]  EBUTP_ADDR_PCON   = 3'h2;  // Power control register one
	localparam logic [2:0]  EBUTP_ADDR_IFLAG  = 3'h3;  // Interrupt flag register
	localparam logic [2:0]  EBUTP_ADDR_IENA   = 3'h4;  // Interrupt enable register

	// Field positions in the timer mode register
	localparam int unsigned EBUTP_MODE_LOW_SPEED_BIT = 7;
	localparam int unsigned EBUTP_MODE_SOURCE_BIT    = 5;
	localparam int unsigned EBUTP_MODE_EDGE_BIT      = 4;
	localparam int unsigned EBUTP_MODE_ASSIGN_BIT    = 3;
	localparam int unsigned EBUTP_MODE_RATIO_LSB     = 0;

	// Field positions in the other registers
	localparam int unsigned EBUTP_PCON_GIE_BIT       = 7;
	localparam int unsigned EBUTP_PCON_ENABLE_BIT    = 0;
	localparam int unsigned EBUTP_IFLAG_OVF_BIT      = 0;
	localparam int unsigned EBUTP_IENA_OVF_BIT       = 0;

	// Reset values
	localparam logic [7:0]  EBUTP_COUNT_RESET = 8'h00;
	localparam logic [7:0]  EBUTP_MODE_RESET  = 8'h08;  // Prescaler on the watchdog
	localparam logic [7:0]  EBUTP_ZERO_BYTE   = 8'h00;
	localparam logic [7:0]  EBUTP_COUNT_MAX   = 8'hff;
	localparam logic [7:0]  EBUTP_COUNT_STEP  = 8'h01;

endpackage

/* File: ebutp_prescaler.sv */
/*
 * Shared power-of-two prescaler. Divides a one-cycle tick stream by
 * 2 to 2**WIDTH, chosen by a ratio field, and clears on request.
 * Assumes ticks are single-cycle pulses synchronous to clk_in.
 */
`timescale 1ns/100ps

module ebutp_prescaler
	import ebutp_pkg::*;
#(
	parameter int unsigned WIDTH   = 8,
	parameter int unsigned RATIO_W = 3
)
(
	input  wire logic               clk_in,
	input  wire logic               rst_in,
	input  wire logic               tick_in,
	input  wire logic               clear_in,
	input  wire logic [RATIO_W-1:0] ratio_in,
	output logic                    tick_out
);

	logic [WIDTH-1:0] count_reg;
	logic [WIDTH-1:0] count_next;
	logic [WIDTH-1:0] ratio_mask;
	logic             terminal;

	////////////////////////////////////////////////////////////////////////
	// Mask of the low count bits that must all be one for a ratio
	genvar i;
	generate
		for (i = 0; i < WIDTH; i++)
		begin : g_mask
			assign ratio_mask[i] = (ratio_in >= RATIO_W'(i));
		end
	endgenerate

	// Output fires on the tick that completes one division period
	assign terminal   = ((count_reg & ratio_mask) == ratio_mask);
	assign tick_out   = tick_in & terminal;
	assign count_next = clear_in ? WIDTH'(0) :
	                    tick_in  ? count_reg + WIDTH'(1) : count_reg;

	////////////////////////////////////////////////////////////////////////
	// Free-running divider count; clear wins so an assignment to the timer starts clean
	always_ff @(posedge clk_in)
	begin
		if (rst_in)
			count_reg <= '0;
		else
			count_reg <= count_next;
	end

endmodule

/* File: ebutp_timer.sv */
/*
 * Eight-bit up-counting timer with selectable count source, edge
 * select, shared prescaler, sticky overflow flag and interrupt request.
 * Assumes a single 25 MHz clock, a synchronous active-high reset, and
 * that all pin and oscillator inputs are already synchronous to clk_in.
 */

`timescale 1ns/100ps

module ebutp_timer
	import ebutp_pkg::*;
#(
	parameter int unsigned COUNT_W = 8,
	parameter int unsigned PRE_W   = 8
)
(
	input  wire logic                    clk_in,
	input  wire logic                    rst_in,
	input  wire logic [EBUTP_ADDR_W-1:0] addr_in,
	input  wire logic [EBUTP_DATA_W-1:0] wr_data_in,
	input  wire logic                    wr_in,
	input  wire logic                    rd_in,
	output logic      [EBUTP_DATA_W-1:0] rd_data_out,
	input  wire logic                    instr_tick_in,
	input  wire logic                    external_count_pin_in,
	input  wire logic                    internal_low_rc_osc_in,
	input  wire logic                    external_low_crystal_in,
	input  wire logic                    low_crystal_config_in,
	input  wire logic                    watchdog_tick_in,
	output logic                         watchdog_tick_out,
	output logic                         irq_out
);

	////////////////////////////////////////////////////////////////////////
	// Software-visible state
	logic [COUNT_W-1:0]      count_reg;
	logic [COUNT_W-1:0]      count_next;
	logic [EBUTP_DATA_W-1:0] timer_mode_register;
	logic                    timer_enable_reg;
	logic                    global_interrupt_enable_reg;
	logic                    timer_overflow_flag_reg;
	logic                    timer_overflow_flag_next;
	logic                    timer_interrupt_enable_reg;

	// Outputs and edge history
	logic [EBUTP_DATA_W-1:0] rd_data_reg;
	logic [EBUTP_DATA_W-1:0] rd_data_next;
	logic                    irq_reg;
	logic                    watchdog_tick_reg;
	logic                    level_prev_reg;

	// Decoded fields of the mode register
	logic                     count_source_select;
	logic                     low_speed_source_select;
	logic                     count_edge_select;
	logic                     prescaler_assign;
	logic [EBUTP_RATIO_W-1:0] prescaler_ratio_select;

	// Address decode
	logic wr_count;
	logic wr_mode;
	logic wr_pcon;
	logic wr_iflag;
	logic wr_iena;

	// Count path: level mux, edge detector, prescaler and the final
	// enable gate, in the order a source event travels through them
	logic low_speed_level;
	logic source_level;
	logic rise_seen;
	logic fall_seen;
	logic pin_event;
	logic source_tick;
	logic pre_in_tick;
	logic pre_out_tick;
	logic pre_clear;
	logic count_event;
	logic overflow;

	////////////////////////////////////////////////////////////////////////
	// Mode register fields
	assign count_source_select     = timer_mode_register[EBUTP_MODE_SOURCE_BIT];
	assign low_speed_source_select = timer_mode_register[EBUTP_MODE_LOW_SPEED_BIT];
	assign count_edge_select       = timer_mode_register[EBUTP_MODE_EDGE_BIT];
	assign prescaler_assign        = timer_mode_register[EBUTP_MODE_ASSIGN_BIT];
	assign prescaler_ratio_select  =
		timer_mode_register[EBUTP_MODE_RATIO_LSB +: EBUTP_RATIO_W];

	// Register map, every register one byte:
	//   count  live count; a write loads it, a read leaves it untouched
	//   mode   [7] low-speed source, [5] external source or instruction tick, [4] falling edge,
	//          [3] prescaler on the watchdog, [2:0] divide by 2**(field+1)
	//   pcon   [7] global interrupt enable, [0] timer enable
	//   iflag  [0] overflow flag; writing 0 clears it, writing 1 forces it
	//   iena   [0] overflow interrupt enable
	// Any other address reads zero and swallows writes.

	// Write strobes per register
	assign wr_count = wr_in & (addr_in == EBUTP_ADDR_COUNT);
	assign wr_mode  = wr_in & (addr_in == EBUTP_ADDR_MODE);
	assign wr_pcon  = wr_in & (addr_in == EBUTP_ADDR_PCON);
	assign wr_iflag = wr_in & (addr_in == EBUTP_ADDR_IFLAG);
	assign wr_iena  = wr_in & (addr_in == EBUTP_ADDR_IENA);

	////////////////////////////////////////////////////////////////////////
	// Source selection. The low-speed oscillator choice is a strap, so it
	// only steers a mux and is never stored here.
	assign low_speed_level = low_crystal_config_in ? external_low_crystal_in
	                                               : internal_low_rc_osc_in;
	assign source_level    = low_speed_source_select ? low_speed_level
	                                                 : external_count_pin_in;

	// Levels are sampled once per clock: a source pulse shorter than one
	// clock period is lost outright, and no prescaler setting recovers it.
	// Edge detection on the chosen level; edge bit picks the direction
	assign rise_seen   = source_level & ~level_prev_reg;
	assign fall_seen   = ~source_level & level_prev_reg;
	assign pin_event   = count_edge_select ? fall_seen : rise_seen;
	assign source_tick = count_source_select ? pin_event : instr_tick_in;

	// Prescaler input: watchdog tick when the assign bit is set, else the timer source
	assign pre_in_tick = prescaler_assign ? watchdog_tick_in : source_tick;

	// Any instruction writing zero to the assign bit restarts the divider
	assign pre_clear = wr_mode & ~wr_data_in[EBUTP_MODE_ASSIGN_BIT];

	// Undivided when the prescaler serves the watchdog. A disabled timer
	// drops events rather than saving them up for later.
	assign count_event = timer_enable_reg &
	                     (prescaler_assign ? source_tick : pre_out_tick);

	////////////////////////////////////////////////////////////////////////
	// Shared prescaler. It divides whichever stream the assign bit hands it,
	// so timer and watchdog never share a division period. A slow oscillator
	// source is best run with a ratio of eight or more so that a late edge
	// only delays the count instead of costing one.
	ebutp_prescaler #(
		.WIDTH   (PRE_W),
		.RATIO_W (EBUTP_RATIO_W)
	) u_prescaler (
		.clk_in   (clk_in),
		.rst_in   (rst_in),
		.tick_in  (pre_in_tick),
		.clear_in (pre_clear),
		.ratio_in (prescaler_ratio_select),
		.tick_out (pre_out_tick)
	);

	////////////////////////////////////////////////////////////////////////
	// Count update. A software load in the same cycle as a count event
	// wins, so the written value is exactly what software reads back.
	assign overflow   = count_event & (count_reg == COUNT_W'(EBUTP_COUNT_MAX));
	assign count_next = wr_count    ? COUNT_W'(wr_data_in) :
	                    count_event ? count_reg + COUNT_W'(EBUTP_COUNT_STEP) :
	                    count_reg;

	// Overflow flag: hardware set beats a simultaneous software clear
	assign timer_overflow_flag_next =
		overflow ? 1'b1 :
		wr_iflag ? wr_data_in[EBUTP_IFLAG_OVF_BIT] :
		timer_overflow_flag_reg;

	////////////////////////////////////////////////////////////////////////
	// Read mux; unmapped addresses read as zero. Reads have no side effect.
	// The result is registered, so data appear the cycle after the strobe
	// and drop back to zero one cycle later.
	always_comb
	begin
		rd_data_next = EBUTP_ZERO_BYTE;
		case (addr_in)
			EBUTP_ADDR_COUNT:
			begin
				rd_data_next = EBUTP_DATA_W'(count_reg);
			end
			EBUTP_ADDR_MODE:
			begin
				rd_data_next = timer_mode_register;
			end
			EBUTP_ADDR_PCON:
			begin
				rd_data_next[EBUTP_PCON_GIE_BIT]    = global_interrupt_enable_reg;
				rd_data_next[EBUTP_PCON_ENABLE_BIT] = timer_enable_reg;
			end
			EBUTP_ADDR_IFLAG:
			begin
				rd_data_next[EBUTP_IFLAG_OVF_BIT] = timer_overflow_flag_reg;
			end
			EBUTP_ADDR_IENA:
			begin
				rd_data_next[EBUTP_IENA_OVF_BIT] = timer_interrupt_enable_reg;
			end
			default:
			begin
				rd_data_next = EBUTP_ZERO_BYTE;
			end
		endcase
	end

	////////////////////////////////////////////////////////////////////////
	// Counter and flag. Both share one process so a wrap and the flag it
	// raises always land on the same clock edge.
	always_ff @(posedge clk_in)
	begin
		if (rst_in)
		begin
			count_reg               <= COUNT_W'(EBUTP_COUNT_RESET);
			timer_overflow_flag_reg <= 1'b0;
		end
		else
		begin
			count_reg               <= count_next;
			timer_overflow_flag_reg <= timer_overflow_flag_next;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Configuration registers. A new ratio applies from the next tick on;
	// the divider itself only restarts on a write with the assign bit clear.
	always_ff @(posedge clk_in)
	begin
		if (rst_in)
			timer_mode_register <= EBUTP_MODE_RESET;
		else if (wr_mode)
			timer_mode_register <= wr_data_in;
	end

	// Power control: global interrupt enable and timer enable.
	// Clearing the timer enable freezes the count where it stands.
	always_ff @(posedge clk_in)
	begin
		if (rst_in)
		begin
			global_interrupt_enable_reg <= 1'b0;
			timer_enable_reg            <= 1'b0;
		end
		else if (wr_pcon)
		begin
			global_interrupt_enable_reg <= wr_data_in[EBUTP_PCON_GIE_BIT];
			timer_enable_reg            <= wr_data_in[EBUTP_PCON_ENABLE_BIT];
		end
	end

	// Interrupt enable acts as the mask of the flag register.
	// Masking hides the request only; the flag itself keeps its state.
	always_ff @(posedge clk_in)
	begin
		if (rst_in)
			timer_interrupt_enable_reg <= 1'b0;
		else if (wr_iena)
			timer_interrupt_enable_reg <= wr_data_in[EBUTP_IENA_OVF_BIT];
	end

	////////////////////////////////////////////////////////////////////////
	// Edge history tracks the selected level every cycle, so a mux change
	// can itself look like an edge; software should reconfigure disabled.
	always_ff @(posedge clk_in)
	begin
		if (rst_in)
			level_prev_reg <= 1'b0;
		else
			level_prev_reg <= source_level;
	end

	////////////////////////////////////////////////////////////////////////
	// Registered outputs. Interrupt lags the flag by one cycle; the
	// extra cycle buys glitch-free pins at the cost of response time.
	// The watchdog tick is a one-cycle pulse, one clock after its input.
	always_ff @(posedge clk_in)
	begin
		if (rst_in)
		begin
			rd_data_reg       <= EBUTP_ZERO_BYTE;
			irq_reg           <= 1'b0;
			watchdog_tick_reg <= 1'b0;
		end
		else
		begin
			rd_data_reg       <= rd_in ? rd_data_next : EBUTP_ZERO_BYTE;
			irq_reg           <= timer_overflow_flag_reg &
			                     timer_interrupt_enable_reg &
			                     global_interrupt_enable_reg;
			watchdog_tick_reg <= prescaler_assign & pre_out_tick;
		end
	end

	assign rd_data_out       = rd_data_reg;
	assign irq_out           = irq_reg;
	assign watchdog_tick_out = watchdog_tick_reg;

endmodule

/* File: ebutp_timer_asserts.sv */
/*
 * Concurrent checks on the ports of the eight-bit timer.
 * Assumes the single-clock register port and a synchronous reset.
 */
`timescale 1ns/100ps

module ebutp_timer_asserts
	import ebutp_pkg::*;
#(
	parameter int unsigned COUNT_W = 8,
	parameter int unsigned PRE_W   = 8
)
(
	input wire logic       clk_in,
	input wire logic       rst_in,
	input wire logic [2:0] addr_in,
	input wire logic [7:0] wr_data_in,
	input wire logic       wr_in,
	input wire logic       rd_in,
	input wire logic [7:0] rd_data_out,
	input wire logic       watchdog_tick_in,
	input wire logic       watchdog_tick_out,
	input wire logic       irq_out
);

////////////////////////////////////////////////////////////////////////
// Shadow copies of software-owned registers, kept from bus writes only
wire       wr_mode = wr_in && addr_in == EBUTP_ADDR_MODE;
wire       wr_pcon = wr_in && addr_in == EBUTP_ADDR_PCON;
wire       wr_iena = wr_in && addr_in == EBUTP_ADDR_IENA;
wire       wr_cnt  = wr_in && addr_in == EBUTP_ADDR_COUNT;
logic [7:0] mode_sh, pcon_sh, cnt_sh;
logic       ie_sh, cnt_ok;

// Count shadow is only trusted while counting stayed off since the load
always_ff @(posedge clk_in)
begin
	mode_sh <= rst_in ? EBUTP_MODE_RESET : (wr_mode ? wr_data_in : mode_sh);
	pcon_sh <= rst_in ? EBUTP_ZERO_BYTE : (wr_pcon ? wr_data_in : pcon_sh);
	ie_sh   <= rst_in ? 1'b0 : (wr_iena ? wr_data_in[0] : ie_sh);
	cnt_sh  <= rst_in ? EBUTP_COUNT_RESET : (wr_cnt ? wr_data_in : cnt_sh);
	cnt_ok  <= rst_in | wr_cnt | (cnt_ok & ~pcon_sh[0]);
end

////////////////////////////////////////////////////////////////////////
default clocking @(posedge clk_in); endclocking
default disable iff (rst_in);

chk_rd_idle_zero: assert property (
	!$past(rd_in) |-> rd_data_out == EBUTP_ZERO_BYTE) else $error("read data not idle");
chk_unmapped_zero: assert property (
	rd_in && addr_in > EBUTP_ADDR_IENA |=> rd_data_out == 8'h00) else $error("unmapped read");
chk_count_held: assert property (
	rd_in && addr_in == EBUTP_ADDR_COUNT && !pcon_sh[0] && cnt_ok
	|=> rd_data_out == $past(cnt_sh)) else $error("loaded count lost");
chk_mode_readback: assert property (
	rd_in && addr_in == EBUTP_ADDR_MODE |=> rd_data_out == $past(mode_sh))
	else $error("mode readback");
chk_pcon_readback: assert property (
	rd_in && addr_in == EBUTP_ADDR_PCON |=> rd_data_out == ($past(pcon_sh) & 8'h81))
	else $error("power control readback");
chk_irq_gated: assert property (
	irq_out |-> $past(pcon_sh[7]) && $past(ie_sh)) else $error("irq without enables");
chk_irq_on_flag: assert property (
	wr_in && addr_in == EBUTP_ADDR_IFLAG && wr_data_in[0] && pcon_sh[7] && ie_sh ##1 !wr_in
	|=> irq_out) else $error("irq missing");
chk_wdog_late: assert property (
	watchdog_tick_out |-> $past(watchdog_tick_in) && $past(mode_sh[3]))
	else $error("watchdog tick unexpected");

endmodule

bind ebutp_timer ebutp_timer_asserts #(.COUNT_W(COUNT_W), .PRE_W(PRE_W)) u_chk (
	.clk_in(clk_in), .rst_in(rst_in), .addr_in(addr_in), .wr_data_in(wr_data_in),
	.wr_in(wr_in), .rd_in(rd_in), .rd_data_out(rd_data_out),
	.watchdog_tick_in(watchdog_tick_in), .watchdog_tick_out(watchdog_tick_out),
	.irq_out(irq_out));

/* File: ebutp_timer_bench.sv */
/*
 * Self-checking bench of the eight-bit timer, driving every port.
 * Assumes a 25 MHz clock and the package register map.
 */
`timescale 1ns/100ps

module ebutp_timer_bench
	import ebutp_pkg::*;
;
logic       clk_in = 1'b0, rst_in = 1'b1, wr_in = 1'b0, rd_in = 1'b0, cfg = 1'b0;
logic [1:0] pv     = 2'b00;
logic [2:0] addr   = 3'h0, src = 3'h0;
logic [7:0] wdata  = 8'h00;
wire  [7:0] rdata;
wire        irq, wdog_out;
int         mismatches = 0, cmp_count = 0, wd_cnt = 0;

always #20 clk_in = ~clk_in;
always @(posedge clk_in) if (wdog_out === 1'b1) wd_cnt <= wd_cnt + 1;

ebutp_timer u_dut (.clk_in(clk_in), .rst_in(rst_in), .addr_in(addr), .wr_data_in(wdata),
	.wr_in(wr_in), .rd_in(rd_in), .rd_data_out(rdata), .instr_tick_in(pv[0]),
	.external_count_pin_in(src[0]), .internal_low_rc_osc_in(src[1]),
	.external_low_crystal_in(src[2]), .low_crystal_config_in(cfg),
	.watchdog_tick_in(pv[1]), .watchdog_tick_out(wdog_out), .irq_out(irq));

////////////////////////////////////////////////////////////////////////
// Bus cycles and comparison; strobes drop one edge later, so calls may chain
task chk(input string n, input logic [7:0] e, input logic [7:0] g);
	cmp_count++;
	if (g !== e)
	begin
		mismatches++;
		$display("[ERR] %s expected %h seen %h", n, e, g);
	end
endtask
task wr(input logic [2:0] a, input logic [7:0] d);
	@(posedge clk_in);
	addr <= a; wdata <= d; wr_in <= 1'b1;
	@(posedge clk_in);
	wr_in <= 1'b0;
endtask
task rd(input string n, input logic [2:0] a, input logic [7:0] e);
	@(posedge clk_in);
	addr <= a; rd_in <= 1'b1;
	@(posedge clk_in);
	rd_in <= 1'b0;
	@(negedge clk_in);
	chk(n, e, rdata);
endtask
task ticks(input int n, input logic [1:0] sel);
	repeat (n)
	begin
		@(posedge clk_in) pv <= sel;
		@(posedge clk_in) pv <= 2'b00;
	end
endtask
task irq_is(input logic e);
	repeat (2) @(negedge clk_in);
	chk("irq", {7'h0, e}, {7'h0, irq});
endtask

////////////////////////////////////////////////////////////////////////
// Scenarios
task t_reset;
	rd("count", EBUTP_ADDR_COUNT, EBUTP_COUNT_RESET);
	rd("mode", EBUTP_ADDR_MODE, EBUTP_MODE_RESET);
	rd("pcon", EBUTP_ADDR_PCON, 8'h00);
	rd("iflag", EBUTP_ADDR_IFLAG, 8'h00);
	rd("iena", EBUTP_ADDR_IENA, 8'h00);
	rd("unmapped", 3'h7, 8'h00);
endtask
// Undivided ticks across the wrap, then counting off and a load
task t_wrap;
	wr(EBUTP_ADDR_PCON, 8'h01);
	wr(EBUTP_ADDR_COUNT, 8'hfe);
	ticks(2, 2'b01);
	rd("count", EBUTP_ADDR_COUNT, 8'h00);
	rd("flag", EBUTP_ADDR_IFLAG, 8'h01);
	rd("flag", EBUTP_ADDR_IFLAG, 8'h01);
	wr(EBUTP_ADDR_PCON, 8'h00);
	ticks(3, 2'b01);
	rd("count", EBUTP_ADDR_COUNT, 8'h00);
	wr(EBUTP_ADDR_COUNT, 8'h5a);
	rd("count", EBUTP_ADDR_COUNT, 8'h5a);
endtask
task t_irq;
	wr(EBUTP_ADDR_IENA, 8'h01);
	wr(EBUTP_ADDR_PCON, 8'h80);
	irq_is(1'b1);
	wr(EBUTP_ADDR_IENA, 8'h00);
	irq_is(1'b0);
	wr(EBUTP_ADDR_IFLAG, 8'h00);
	wr(EBUTP_ADDR_IENA, 8'h01);
	irq_is(1'b0);
	wr(EBUTP_ADDR_IFLAG, 8'h01);
	irq_is(1'b1);
	wr(EBUTP_ADDR_IFLAG, 8'h00);
endtask
// Every ratio: one event exactly on the 2**(n+1)th tick after the clear
task t_prescale;
	wr(EBUTP_ADDR_PCON, 8'h01);
	for (int n = 0; n < 8; n++)
	begin
		wr(EBUTP_ADDR_MODE, n[7:0]);
		wr(EBUTP_ADDR_COUNT, 8'h00);
		ticks((2 << n) - 1, 2'b01);
		rd("count", EBUTP_ADDR_COUNT, 8'h00);
		ticks(1, 2'b01);
		rd("count", EBUTP_ADDR_COUNT, 8'h01);
	end
	wr(EBUTP_ADDR_MODE, 8'h01);
	ticks(2, 2'b01);
	wr(EBUTP_ADDR_MODE, 8'h01);
	wr(EBUTP_ADDR_COUNT, 8'h00);
	ticks(3, 2'b01);
	rd("count", EBUTP_ADDR_COUNT, 8'h00);
endtask
// One full high-then-low pulse on a source level, changed at rising edges
task pulse(input int w);
	src[w] <= 1'b1;
	repeat (3) @(posedge clk_in);
	src[w] <= 1'b0;
	repeat (3) @(posedge clk_in);
endtask
// Pin source with both edge settings, low RC on the rising and low crystal on the falling edge
task t_edge;
	logic [7:0] m;
	int w;
	for (int k = 0; k < 4; k++)
	begin
		// Oscillator sources go through a divide-by-8 prescaler, the pin undivided
		m = (k[0] ? 8'h10 : 8'h00) | (k[1] ? 8'ha2 : 8'h28);
		w = k[1] ? (k[0] ? 2 : 1) : 0;
		wr(EBUTP_ADDR_MODE, m);
		cfg <= (k == 3);
		wr(EBUTP_ADDR_COUNT, 8'h00);
		repeat (k[1] ? 7 : 0) pulse(w);
		src[w] <= 1'b1;
		repeat (3) @(posedge clk_in);
		rd("count", EBUTP_ADDR_COUNT, {7'h0, ~m[4]});
		@(posedge clk_in);
		src[w] <= 1'b0;
		repeat (3) @(posedge clk_in);
		rd("count", EBUTP_ADDR_COUNT, 8'h01);
	end
endtask
task t_wdog;
	int base;
	wr(EBUTP_ADDR_MODE, 8'h00);
	wr(EBUTP_ADDR_MODE, 8'h08);
	base = wd_cnt;
	ticks(4, 2'b10);
	repeat (3) @(posedge clk_in);
	chk("watchdog ticks", 8'h02, 8'(wd_cnt - base));
endtask

////////////////////////////////////////////////////////////////////////
task end_of_test;
	$display("mismatches %0d comparisons %0d", mismatches, cmp_count);
	if (mismatches == 0 && cmp_count > 0)
		$display("verification passed");
	else
		$display("verification failed");
	$finish;
endtask

// Whole sequence needs about 1300 cycles; the guard allows 10000
initial
begin
	#400000;
	mismatches++;
	end_of_test;
end
initial
begin
	repeat (3) @(posedge clk_in);
	rst_in <= 1'b0;
	@(posedge clk_in);
	t_reset;
	t_wrap;
	t_irq;
	t_prescale;
	t_edge;
	t_wdog;
	end_of_test;
end

endmodule
